/* File: design/msd_pkg.sv */
// Constants, field layout and state codes for the memory-space decoder.
// Assumes a single core clock that is also the oscillator the strobe divider counts.
package msd_pkg;
    localparam logic [7:0]  MSD_CTRL_ADDR   = 8'h8e;
    localparam logic [2:0]  MSD_CTRL_RESET  = 3'b010;
    localparam int          MSD_PUMP_BIT    = 2;
    localparam int          MSD_BYPASS_BIT  = 1;
    localparam int          MSD_QUIET_BIT   = 0;
    localparam logic [15:0] MSD_ROM_TOP     = 16'h3fff;
    localparam logic [7:0]  MSD_LOWER_TOP   = 8'h7f;
    localparam logic [15:0] MSD_AUX_TOP     = 16'h00ff;
    localparam int          MSD_AUX_DEPTH   = 256;
    localparam logic [2:0]  MSD_ALE_LAST    = 3'h5;
    localparam logic [1:0]  MSD_DATA_LAST   = 2'h2;
    typedef enum logic [1:0] {
        MSD_IDLE = 2'b00,
        MSD_ADDR = 2'b01,
        MSD_DATA = 2'b11
    } msd_state_t;
endpackage : msd_pkg

/* File: design/msd_decoder.sv */
// Memory-space decoder: fetch steering, internal data split, move routing, bus cycles.
// Assumes the core holds each request for one cycle and waits on busy/done.
`timescale 1ns/1ps
module msd_decoder
    import msd_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Strap pin, low forces external fetch
    input  wire logic        ext_fetch_select_n,
    // Instruction fetch request
    input  wire logic        fetch_req,
    input  wire logic [15:0] fetch_addr,
    output logic             fetch_internal_q,
    output logic             fetch_external_q,
    // Internal data access
    input  wire logic        data_req,
    input  wire logic        data_direct,
    input  wire logic        data_stack,
    input  wire logic [7:0]  data_addr,
    output logic             sel_lower_ram_q,
    output logic             sel_upper_ram_q,
    output logic             sel_special_q,
    // External data move request
    input  wire logic        ext_data_move,
    input  wire logic        move_use_pointer,
    input  wire logic        move_write,
    input  wire logic [15:0] move_addr,
    input  wire logic [7:0]  move_wdata,
    input  wire logic        code_table_move,
    input  wire logic [7:0]  high_port_sfr,
    output logic             move_busy_q,
    output logic             move_done_q,
    output logic [7:0]       move_rdata_q,
    // Special register access
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata_q,
    // Control bits
    output logic             converter_pump_on_q,
    output logic             aux_ram_bypass_q,
    output logic             latch_strobe_quiet_q,
    // External bus pins
    input  wire logic [7:0]  low_bus_port_in,
    output logic [7:0]       low_bus_port_out_q,
    output logic             low_bus_port_oe_q,
    output logic [7:0]       high_bus_port_q,
    output logic             addr_latch_strobe_q,
    output logic             write_strobe_n_q,
    output logic             read_strobe_n_q
);
    logic        sel_sync1_q, sel_sync2_q, sel_latched_q;
    logic [7:0]  low_sync1_q, low_sync2_q;
    logic [7:0]  aux_mem [MSD_AUX_DEPTH];
    logic [2:0]  ale_div_q;
    logic [1:0]  phase_q;
    msd_state_t  state_q;
    logic        is_aux, is_ext, accept;
    logic        cyc_ptr_q, cyc_write_q;
    logic [15:0] cyc_addr_q;
    logic [7:0]  cyc_wdata_q;
    logic        ctrl_wr;

    // Pin synchronisers; no reset since they only follow the pins
    always_ff @(posedge ref_clk) begin
        sel_sync1_q <= ext_fetch_select_n;
        sel_sync2_q <= sel_sync1_q;
        low_sync1_q <= low_bus_port_in;
        low_sync2_q <= low_sync1_q;
    end

    // Strap is sampled on every edge while reset is held, then frozen
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sel_latched_q <= sel_sync2_q;
        end
    end

    // Fetch steering
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fetch_internal_q <= 1'b0;
            fetch_external_q <= 1'b0;
        end else begin
            fetch_internal_q <= fetch_req & sel_latched_q & (fetch_addr <= MSD_ROM_TOP);
            fetch_external_q <= fetch_req & (~sel_latched_q | (fetch_addr > MSD_ROM_TOP));
        end
    end

    // Internal data split; stack traffic is indirect by nature
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_lower_ram_q <= 1'b0;
            sel_upper_ram_q <= 1'b0;
            sel_special_q   <= 1'b0;
        end else begin
            sel_lower_ram_q <= data_req & (data_addr <= MSD_LOWER_TOP);
            sel_upper_ram_q <= data_req & (data_addr > MSD_LOWER_TOP)
                               & (~data_direct | data_stack);
            sel_special_q   <= data_req & (data_addr > MSD_LOWER_TOP)
                               & data_direct & ~data_stack;
        end
    end

    // Control register; reserved bits are not stored and read as zero
    assign ctrl_wr = sfr_wr & (sfr_addr == MSD_CTRL_ADDR);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            converter_pump_on_q  <= MSD_CTRL_RESET[MSD_PUMP_BIT];
            aux_ram_bypass_q     <= MSD_CTRL_RESET[MSD_BYPASS_BIT];
            latch_strobe_quiet_q <= MSD_CTRL_RESET[MSD_QUIET_BIT];
        end else if (ctrl_wr) begin
            converter_pump_on_q  <= sfr_wdata[MSD_PUMP_BIT];
            aux_ram_bypass_q     <= sfr_wdata[MSD_BYPASS_BIT];
            latch_strobe_quiet_q <= sfr_wdata[MSD_QUIET_BIT];
        end
    end

    // Register read-back
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_addr == MSD_CTRL_ADDR) begin
            sfr_rdata_q <= {5'h00, converter_pump_on_q, aux_ram_bypass_q,
                            latch_strobe_quiet_q};
        end else begin
            sfr_rdata_q <= 8'h00;
        end
    end

    // Move routing; an index move is inside the first page unless aux_ram_bypass_q is set
    assign is_aux = ~aux_ram_bypass_q
                    & (~move_use_pointer | (move_addr <= MSD_AUX_TOP));
    assign is_ext = ~is_aux;
    assign accept = ext_data_move & (state_q == MSD_IDLE);

    // Auxiliary RAM; a single-cycle access that never touches the pins
    always_ff @(posedge ref_clk) begin
        if (accept & is_aux & move_write) begin
            aux_mem[move_addr[7:0]] <= move_wdata;
        end
    end

    // Strobe divider free-runs so the 1/6 rate stays even across bus cycles
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ale_div_q <= 3'h0;
        end else if (ale_div_q == MSD_ALE_LAST) begin
            ale_div_q <= 3'h0;
        end else begin
            ale_div_q <= ale_div_q + 3'h1;
        end
    end

    // Address strobe: constant rate, or only in move phases when quiet
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_latch_strobe_q <= 1'b0;
        end else begin
            addr_latch_strobe_q <= (~latch_strobe_quiet_q & (ale_div_q == 3'h0))
                                   | (accept & is_ext)
                                   | (latch_strobe_quiet_q & code_table_move
                                      & (ale_div_q == 3'h0));
        end
    end

    // Bus cycle sequencer: address phase, then a three-cycle data phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q     <= MSD_IDLE;
            phase_q     <= 2'h0;
            cyc_ptr_q   <= 1'b0;
            cyc_write_q <= 1'b0;
            cyc_addr_q  <= 16'h0000;
            cyc_wdata_q <= 8'h00;
        end else begin
            unique case (state_q)
                MSD_IDLE: begin
                    if (accept & is_ext) begin
                        state_q     <= MSD_ADDR;
                        cyc_ptr_q   <= move_use_pointer;
                        cyc_write_q <= move_write;
                        cyc_addr_q  <= move_addr;
                        cyc_wdata_q <= move_wdata;
                    end
                end
                MSD_ADDR: begin
                    state_q <= MSD_DATA;
                    phase_q <= 2'h0;
                end
                MSD_DATA: begin
                    phase_q <= phase_q + 2'h1;
                    if (phase_q == MSD_DATA_LAST) begin
                        state_q <= MSD_IDLE;
                    end
                end
            endcase
        end
    end

    // Pin drive, registered from the state being entered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_bus_port_out_q <= 8'h00;
            low_bus_port_oe_q  <= 1'b0;
            high_bus_port_q    <= 8'h00;
            write_strobe_n_q   <= 1'b1;
            read_strobe_n_q    <= 1'b1;
        end else if (accept & is_ext) begin
            low_bus_port_out_q <= move_addr[7:0];
            low_bus_port_oe_q  <= 1'b1;
            high_bus_port_q    <= move_use_pointer ? move_addr[15:8] : high_port_sfr;
        end else if ((state_q == MSD_ADDR)
                     | ((state_q == MSD_DATA) & (phase_q != MSD_DATA_LAST))) begin
            low_bus_port_out_q <= cyc_wdata_q;
            low_bus_port_oe_q  <= cyc_write_q;
            write_strobe_n_q   <= ~cyc_write_q;
            read_strobe_n_q    <= cyc_write_q;
            high_bus_port_q    <= cyc_ptr_q ? cyc_addr_q[15:8] : high_port_sfr;
        end else begin
            low_bus_port_oe_q  <= 1'b0;
            write_strobe_n_q   <= 1'b1;
            read_strobe_n_q    <= 1'b1;
            high_bus_port_q    <= high_port_sfr;
        end
    end

    // Completion and read data; external data is taken late for the sync lag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            move_done_q  <= 1'b0;
            move_busy_q  <= 1'b0;
            move_rdata_q <= 8'h00;
        end else begin
            move_busy_q <= (accept & is_ext) | ((state_q != MSD_IDLE)
                           & ~((state_q == MSD_DATA) & (phase_q == MSD_DATA_LAST)));
            move_done_q <= (accept & is_aux)
                           | ((state_q == MSD_DATA) & (phase_q == MSD_DATA_LAST));
            if (accept & is_aux & ~move_write) begin
                move_rdata_q <= aux_mem[move_addr[7:0]];
            end else if ((state_q == MSD_DATA) & (phase_q == MSD_DATA_LAST) & ~cyc_write_q) begin
                move_rdata_q <= low_sync2_q;
            end
        end
    end

    // Checks
    fetch_split_a: assert property (@(posedge ref_clk) disable iff (rst)
        fetch_req |=> (fetch_internal_q != fetch_external_q))
        else $error("fetch not steered to exactly one memory");
    fetch_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        ~sel_latched_q |-> ~fetch_internal_q)
        else $error("internal fetch with select pin low");
    strap_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        $stable(sel_latched_q))
        else $error("strap changed after reset");
    lower_map_a: assert property (@(posedge ref_clk) disable iff (rst)
        data_req & (data_addr <= MSD_LOWER_TOP) |=> sel_lower_ram_q & ~sel_upper_ram_q)
        else $error("lower ram not selected");
    direct_sfr_a: assert property (@(posedge ref_clk) disable iff (rst)
        data_req & data_direct & ~data_stack & data_addr[7] |=> sel_special_q
        & ~sel_upper_ram_q)
        else $error("direct high access missed special space");
    indirect_up_a: assert property (@(posedge ref_clk) disable iff (rst)
        data_req & (~data_direct | data_stack) & data_addr[7] |=> sel_upper_ram_q
        & ~sel_special_q)
        else $error("indirect high access missed upper ram");
    aux_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        accept & is_aux |=> write_strobe_n_q & read_strobe_n_q & ~low_bus_port_oe_q
        & move_done_q)
        else $error("aux access touched the bus");
    strobe_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
        accept & is_ext & move_write |=> ##1 ~write_strobe_n_q & read_strobe_n_q [*3])
        else $error("write strobe missing");
    ext_done_a: assert property (@(posedge ref_clk) disable iff (rst)
        accept & is_ext |=> ##4 move_done_q)
        else $error("bus cycle length wrong");
    ptr_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        accept & is_ext & move_use_pointer |=> high_bus_port_q == $past(move_addr[15:8]))
        else $error("high byte not on high port");
    ale_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
        ~latch_strobe_quiet_q & addr_latch_strobe_q & ~move_busy_q & ~ext_data_move
        |=> (~addr_latch_strobe_q | move_busy_q) [*4])
        else $error("strobe faster than one in six");
    reset_ctrl_a: assert property (@(posedge ref_clk)
        $fell(rst) |-> aux_ram_bypass_q & ~latch_strobe_quiet_q)
        else $error("control register reset pattern wrong");
    aux_cov_c: cover property (@(posedge ref_clk) disable iff (rst) accept & is_aux);
    ext_rd_c: cover property (@(posedge ref_clk) disable iff (rst)
        accept & is_ext & ~move_write);
    ext_fetch_c: cover property (@(posedge ref_clk) disable iff (rst) fetch_external_q);
    ctrl_wr_c: cover property (@(posedge ref_clk) disable iff (rst) ctrl_wr);
endmodule : msd_decoder

/* File: testbench/msd_ext_mem.sv */
// External data memory model sitting on the multiplexed low and high bus ports.
// Assumes the address is valid while the latch strobe is high, the low port is
// driven and both strobes are idle.
`timescale 1ns/1ps
module msd_ext_mem (
    // Clock
    input  wire logic       ref_clk,
    // Bus from the decoder
    input  wire logic [7:0] low_out,
    input  wire logic       low_oe,
    input  wire logic [7:0] high_port,
    input  wire logic       ale,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    // Data back to the decoder
    output logic      [7:0] low_in
);
    logic [7:0]  mem [0:255];
    logic [15:0] last_addr = 16'h0000;
    logic [7:0]  last_val  = 8'h00;
    logic        wr_q      = 1'b1;
    logic        rd_q      = 1'b1;
    int          wr_cnt    = 0;
    int          rd_cnt    = 0;

    // Released bus shows the inverse of the last value, so stale data never matches
    assign low_in = !rd_n ? mem[last_addr[7:0]] : ~last_val;

    // Address latch, store capture and strobe counting
    always @(posedge ref_clk) begin
        wr_q <= wr_n;
        rd_q <= rd_n;
        if (ale && low_oe && wr_n && rd_n) begin
            last_addr <= {high_port, low_out};
        end
        if (!wr_n) begin
            mem[last_addr[7:0]] <= low_out;
        end
        if (!rd_n) begin
            last_val <= mem[last_addr[7:0]];
        end
        if (wr_q && !wr_n) begin
            wr_cnt <= wr_cnt + 1;
        end
        if (rd_q && !rd_n) begin
            rd_cnt <= rd_cnt + 1;
        end
    end
endmodule : msd_ext_mem

/* File: testbench/msd_decoder_tb_top.sv */
// Self-checking bench for the memory-space decoder with an external memory model.
// Assumes a 50 MHz core clock and the one-cycle request handshakes of the decoder.
`timescale 1ns/1ps
module msd_decoder_tb_top;
    import msd_pkg::*;
    logic        ref_clk = 1'b0, rst = 1'b1, ext_fetch_select_n = 1'b1;
    logic        fetch_req = 1'b0, data_req = 1'b0, data_direct = 1'b0, data_stack = 1'b0;
    logic [15:0] fetch_addr = 16'h0000, move_addr = 16'h0000;
    logic        ext_data_move = 1'b0, move_use_pointer = 1'b0, move_write = 1'b0;
    logic        code_table_move = 1'b0, sfr_wr = 1'b0;
    logic [7:0]  data_addr = 8'h00, move_wdata = 8'h00, high_port_sfr = 8'h00;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic        fi, fe, sl, su, ss, busy, done, pump, byp, quiet, oe, ale, wr_n, rd_n;
    logic [7:0]  rdata, sfr_rdata, lo_out, lo_in, hi;
    int          bad_count = 0, cmp_count = 0, cyc = 0, ale_cnt = 0, a0;

    msd_decoder msd_decoder_inst (.ref_clk(ref_clk), .rst(rst),
        .ext_fetch_select_n(ext_fetch_select_n), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_internal_q(fi), .fetch_external_q(fe),
        .data_req(data_req), .data_direct(data_direct), .data_stack(data_stack),
        .data_addr(data_addr), .sel_lower_ram_q(sl), .sel_upper_ram_q(su),
        .sel_special_q(ss), .ext_data_move(ext_data_move),
        .move_use_pointer(move_use_pointer), .move_write(move_write),
        .move_addr(move_addr), .move_wdata(move_wdata), .code_table_move(code_table_move),
        .high_port_sfr(high_port_sfr), .move_busy_q(busy), .move_done_q(done),
        .move_rdata_q(rdata), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_rdata_q(sfr_rdata), .converter_pump_on_q(pump), .aux_ram_bypass_q(byp),
        .latch_strobe_quiet_q(quiet), .low_bus_port_in(lo_in), .low_bus_port_out_q(lo_out),
        .low_bus_port_oe_q(oe), .high_bus_port_q(hi), .addr_latch_strobe_q(ale),
        .write_strobe_n_q(wr_n), .read_strobe_n_q(rd_n));

    msd_ext_mem msd_ext_mem_inst (.ref_clk(ref_clk), .low_out(lo_out), .low_oe(oe),
        .high_port(hi), .ale(ale), .wr_n(wr_n), .rd_n(rd_n), .low_in(lo_in));

    // Clock, strobe counter and hang guard
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (ale === 1'b1) ale_cnt++;
        if (cyc == 5000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
        tick();
        sfr_wr = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        sfr_addr = a;
        tick();
        chk("ctrl read", {8'h00, e}, {8'h00, sfr_rdata});
    endtask : rd_reg

    task automatic fetch(input logic [15:0] a, input logic e);
        fetch_req = 1'b1; fetch_addr = a;
        tick();
        fetch_req = 1'b0;
        chk("fetch select", {14'h0000, e, ~e}, {14'h0000, fi, fe});
    endtask : fetch

    task automatic dsel(input logic d, input logic s, input logic [7:0] a,
                        input logic [2:0] e);
        data_req = 1'b1; data_direct = d; data_stack = s; data_addr = a;
        tick();
        data_req = 1'b0;
        chk("data select", {13'h0000, e}, {13'h0000, sl, su, ss});
    endtask : dsel

    // Loads expect wd back; ext says whether the bus must run
    task automatic move(input logic p, input logic w, input logic [15:0] a,
                        input logic [7:0] wd, input logic ext);
        int n, w0, r0;
        w0 = msd_ext_mem_inst.wr_cnt; r0 = msd_ext_mem_inst.rd_cnt; n = 0;
        ext_data_move = 1'b1; move_use_pointer = p; move_write = w;
        move_addr = a; move_wdata = wd;
        tick();
        ext_data_move = 1'b0;
        chk("move busy", ext, busy);
        while (done !== 1'b1 && n < 20) begin
            tick(); n++;
        end
        chk("move done", 1, done);
        chk("write strobes", ext & w, msd_ext_mem_inst.wr_cnt - w0);
        chk("read strobes", ext & ~w, msd_ext_mem_inst.rd_cnt - r0);
        chk("move latency", ext ? 16'h0004 : 16'h0000, n);
        if (!ext) chk("high port", high_port_sfr, hi);
        if (ext) chk("bus addr", p ? a : {high_port_sfr, a[7:0]},
                     msd_ext_mem_inst.last_addr);
        if (!w) chk("load data", wd, rdata);
        tick();
    endtask : move

    task automatic ale_run(input int e);
        a0 = ale_cnt;
        repeat (12) tick();
        chk("latch strobes", e, ale_cnt - a0);
    endtask : ale_run

    // Main sequence
    initial begin
        repeat (20) tick();
        rst = 1'b0; ext_fetch_select_n = 1'b0;
        chk("reset bits", 3'b010, {pump, byp, quiet});
        rd_reg(MSD_CTRL_ADDR, 8'h02);
        fetch(16'h3fff, 1'b1);
        fetch(16'h4000, 1'b0);
        fetch(16'hffff, 1'b0);
        fetch(16'h0000, 1'b1);
        dsel(1'b1, 1'b0, 8'h00, 3'b100);
        dsel(1'b0, 1'b0, 8'h7f, 3'b100);
        dsel(1'b1, 1'b0, 8'h80, 3'b001);
        dsel(1'b1, 1'b0, 8'hff, 3'b001);
        dsel(1'b0, 1'b0, 8'h80, 3'b010);
        dsel(1'b0, 1'b1, 8'ha0, 3'b010);
        dsel(1'b0, 1'b1, 8'h10, 3'b100);
        ale_run(2);
        wr_reg(MSD_CTRL_ADDR, 8'h00);
        chk("ctrl bits", 3'b000, {pump, byp, quiet});
        high_port_sfr = 8'hc5;
        move(1'b0, 1'b1, 16'h00a0, 8'h3c, 1'b0);
        move(1'b0, 1'b0, 16'h00a0, 8'h3c, 1'b0);
        move(1'b1, 1'b1, 16'h00ff, 8'hc3, 1'b0);
        move(1'b1, 1'b0, 16'h00ff, 8'hc3, 1'b0);
        move(1'b1, 1'b1, 16'h0100, 8'h5a, 1'b1);
        move(1'b1, 1'b0, 16'h0100, 8'h5a, 1'b1);
        wr_reg(8'h8f, 8'hff);
        rd_reg(8'h8f, 8'h00);
        rd_reg(MSD_CTRL_ADDR, 8'h00);
        wr_reg(MSD_CTRL_ADDR, 8'h07);
        chk("ctrl bits", 3'b111, {pump, byp, quiet});
        rd_reg(MSD_CTRL_ADDR, 8'h07);
        ale_run(0);
        code_table_move = 1'b1;
        tick();
        ale_run(2);
        code_table_move = 1'b0;
        high_port_sfr = 8'h5a;
        move(1'b0, 1'b1, 16'h0035, 8'h77, 1'b1);
        move(1'b0, 1'b0, 16'h0035, 8'h77, 1'b1);
        move(1'b1, 1'b1, 16'h1234, 8'he1, 1'b1);
        move(1'b1, 1'b0, 16'h1234, 8'he1, 1'b1);
        rst = 1'b1;
        repeat (4) tick();
        rst = 1'b0; ext_fetch_select_n = 1'b1;
        chk("reset bits", 3'b010, {pump, byp, quiet});
        fetch(16'h0000, 1'b0);
        fetch(16'h3fff, 1'b0);
        summarize();
    end
endmodule : msd_decoder_tb_top
